// file: rtcr_div.sv
// Prescaler giving 16 Hz and 1 Hz enable pulses
`timescale 1ns/10ps
`default_nettype none
module rtcr_div #(
  parameter int unsigned SUB_TICK_CYCLES = rtcr_pkg::RTCR_SUB_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  output logic tick_16hz,
  output logic tick_1hz
);
  import rtcr_pkg::*;

  typedef struct packed {
    logic [31:0] cnt;
    logic [3:0] sub;
    logic t16;
    logic t1;
  } rtcr_div_t;

  rtcr_div_t st, next_st;

  if (SUB_TICK_CYCLES < 2) begin : g_chk
    $error("SUB_TICK_CYCLES must be at least 2");
  end

  always_comb begin
    next_st = st;
    next_st.t16 = 1'b0;
    next_st.t1 = 1'b0;
    if (clr) begin
      next_st.cnt = '0;
      next_st.sub = '0;
    end else if (st.cnt == 32'(SUB_TICK_CYCLES - 1)) begin
      next_st.cnt = '0;
      next_st.t16 = 1'b1;
      next_st.sub = st.sub + 4'h1;
      next_st.t1 = (st.sub == 4'(RTCR_SUBS_PER_SEC - 1));
    end else begin
      next_st.cnt = st.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_16hz = st.t16;
  assign tick_1hz = st.t1;
endmodule
`default_nettype wire

// file: rtcr_paged_register_file_test.sv
// Self-checking testbench for the paged real-time-clock register file
`timescale 1ns/10ps
`default_nettype none
module rtcr_paged_register_file_test;
  import rtcr_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Short sub-tick so one second is 64 cycles
  localparam int unsigned SUB = 4;
  localparam int SEC_CYC = 16 * SUB;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [RTCR_AW-1:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alarm_out;
  logic pulse_1hz;
  logic pulse_16hz;
  int n_errors = 0;
  int checks_done = 0;
  int n1 = 0;
  int n16 = 0;
  logic cnt_on = 1'b0;
  logic [31:0] rd;
  logic err;

  rtcr_regs #(.SUB_TICK_CYCLES(SUB)) DUT (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .alarm_out(alarm_out),
    .pulse_1hz(pulse_1hz),
    .pulse_16hz(pulse_16hz)
  );

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    if (cnt_on) begin
      if (pulse_1hz === 1'b1) n1++;
      if (pulse_16hz === 1'b1) n16++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until pready is sampled high, then releases
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] wd);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      $display("CHECK FAILED pready expected 1 seen none");
      print_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr8(input logic [13:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
    chk("write error", 32'h0000_0000, {31'h0, err});
  endtask

  task automatic rd8(input string what, input logic [13:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {24'h00_0000, exp}, rd);
    chk("read error", 32'h0000_0000, {31'h0, err});
  endtask

  task automatic read_time(input logic [7:0] s, input logic [7:0] m);
    rd8("seconds", RTCR_IDX_SECONDS, s);
    rd8("minutes", RTCR_IDX_MINUTES, m);
    rd8("hours", RTCR_IDX_HOURS, 8'h23);
    rd8("weekday", RTCR_IDX_WEEKDAY, 8'h05);
    rd8("day", RTCR_IDX_DAY, 8'h31);
    rd8("month", RTCR_IDX_MONTH, 8'h12);
    rd8("year", RTCR_IDX_YEAR, 8'h99);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Software sets the control and page-0 time registers first, nothing is defined after reset
  task automatic t_init();
    chk("pready after reset", 32'h0, {31'h0, pready});
    chk("pslverr after reset", 32'h0, {31'h0, pslverr});
    wr8(RTCR_IDX_PAGE, 8'h00);
    wr8(RTCR_IDX_RESET, 8'h10);
    wr8(RTCR_IDX_SECONDS, 8'h59);
    wr8(RTCR_IDX_MINUTES, 8'h45);
    wr8(RTCR_IDX_HOURS, 8'h23);
    wr8(RTCR_IDX_WEEKDAY, 8'h05);
    wr8(RTCR_IDX_DAY, 8'h31);
    wr8(RTCR_IDX_MONTH, 8'h12);
    wr8(RTCR_IDX_YEAR, 8'h99);
    read_time(8'h59, 8'h45);
  endtask

  task automatic t_page1();
    wr8(RTCR_IDX_PAGE, 8'h01);
    wr8(RTCR_IDX_MINUTES, 8'h30);
    wr8(RTCR_IDX_HOURS, 8'h12);
    wr8(RTCR_IDX_WEEKDAY, 8'h03);
    wr8(RTCR_IDX_DAY, 8'h15);
    wr8(RTCR_IDX_MONTH, 8'h01);
    wr8(RTCR_IDX_YEAR, 8'h02);
    wr8(RTCR_IDX_SECONDS, 8'h11);
    rd8("alarm minutes", RTCR_IDX_MINUTES, 8'h30);
    rd8("alarm hours", RTCR_IDX_HOURS, 8'h12);
    rd8("alarm weekday", RTCR_IDX_WEEKDAY, 8'h03);
    rd8("alarm day", RTCR_IDX_DAY, 8'h15);
    rd8("hour format", RTCR_IDX_MONTH, 8'h01);
    rd8("leap mode", RTCR_IDX_YEAR, 8'h02);
    rd8("seconds on page 1", RTCR_IDX_SECONDS, 8'h00);
    wr8(RTCR_IDX_PAGE, 8'h00);
    read_time(8'h59, 8'h45);
  endtask

  // Reserved page bits must read back zero
  task automatic t_control();
    wr8(RTCR_IDX_PAGE, 8'hE7);
    rd8("page control", RTCR_IDX_PAGE, 8'h85);
    wr8(RTCR_IDX_PAGE, 8'h00);
    rd8("page control clear", RTCR_IDX_PAGE, 8'h00);
    rd8("reset reg read", RTCR_IDX_RESET, 8'h00);
    apb(1'b0, 14'h1329, 8'h00);
    chk("unmapped error", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
  endtask

  task automatic t_sys_reset();
    @(posedge mclk);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    read_time(8'h59, 8'h45);
    rd8("page after reset", RTCR_IDX_PAGE, 8'h00);
  endtask

  // Divider restart fixes the tick phase: two seconds in 2.5 s
  task automatic t_live();
    wr8(RTCR_IDX_SECONDS, 8'h58);
    wr8(RTCR_IDX_PAGE, 8'h08);
    wr8(RTCR_IDX_RESET, 8'hE0);
    cnt_on = 1'b1;
    repeat (SEC_CYC * 2 + SEC_CYC / 2) @(posedge mclk);
    cnt_on = 1'b0;
    wr8(RTCR_IDX_PAGE, 8'h00);
    wr8(RTCR_IDX_RESET, 8'h00);
    chk("1 Hz pulses", 32'd2, n1);
    chk("16 Hz pulses near 40", 32'h1, {31'h0, (n16 >= 39 && n16 <= 41)});
    read_time(8'h00, 8'h46);
  endtask

  // Frozen time matches the alarm fields; only the enable may raise the output
  task automatic t_alarm();
    wr8(RTCR_IDX_SECONDS, 8'h00);
    wr8(RTCR_IDX_MINUTES, 8'h30);
    wr8(RTCR_IDX_HOURS, 8'h12);
    wr8(RTCR_IDX_WEEKDAY, 8'h03);
    wr8(RTCR_IDX_DAY, 8'h15);
    chk("alarm while disabled", 32'h0, {31'h0, alarm_out});
    wr8(RTCR_IDX_PAGE, 8'h04);
    repeat (2) @(posedge mclk);
    chk("alarm on match", 32'h1, {31'h0, alarm_out});
    wr8(RTCR_IDX_PAGE, 8'h00);
    chk("alarm held", 32'h1, {31'h0, alarm_out});
    wr8(RTCR_IDX_RESET, 8'h10);
    @(posedge mclk);
    chk("alarm cleared", 32'h0, {31'h0, alarm_out});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_init();
    t_page1();
    t_control();
    t_sys_reset();
    t_live();
    t_alarm();
    print_verdict();
  end
endmodule
`default_nettype wire

// file: rtcr_pkg.sv
// Package of constants for the paged real-time-clock register file
//
// Functional notes
// - Time, calendar, alarm and control registers are untouched by system reset; their power-up value is undefined.
// - With page 0 selected, reading a time or calendar register returns the live running count.
// - With page 1 selected, the shared addresses return the held alarm and mode settings.
// - Seconds hold BCD 00 to 59 in bits 6:0 with bit 7 reading zero, and software writes no other code.
// - The weekday register carries a three-bit code in bits 2:0 and its upper bits are unused.
// - The year register holds the two low decimal digits of the year as eight-bit BCD.
// - Page 0 maps seconds to year at consecutive addresses from the base, hours bit 5 being the 20-hour digit or PM flag.
// - Page 1 reuses those addresses for alarm minute, hour, weekday and day, a 12/24 select and a two-bit leap mode.
package rtcr_pkg;
  localparam int RTCR_AW = 16;
  // Register indices; byte address is four times the index
  localparam logic [13:0] RTCR_IDX_SECONDS = 14'h1320;
  localparam logic [13:0] RTCR_IDX_MINUTES = 14'h1321;
  localparam logic [13:0] RTCR_IDX_HOURS = 14'h1322;
  localparam logic [13:0] RTCR_IDX_WEEKDAY = 14'h1323;
  localparam logic [13:0] RTCR_IDX_DAY = 14'h1324;
  localparam logic [13:0] RTCR_IDX_MONTH = 14'h1325;
  localparam logic [13:0] RTCR_IDX_YEAR = 14'h1326;
  localparam logic [13:0] RTCR_IDX_PAGE = 14'h1327;
  localparam logic [13:0] RTCR_IDX_RESET = 14'h1328;
  // Page and control bit positions
  localparam int RTCR_PG_PAGE = 0;
  localparam int RTCR_PG_AL_EN = 2;
  localparam int RTCR_PG_CLK_EN = 3;
  localparam int RTCR_PG_ADJ = 4;
  localparam int RTCR_PG_IRQ_EN = 7;
  // Reset register bit positions
  localparam int RTCR_RS_ALARM = 4;
  localparam int RTCR_RS_DIV = 5;
  localparam int RTCR_RS_EN16 = 6;
  localparam int RTCR_RS_EN1 = 7;
  // BCD limits
  localparam logic [7:0] RTCR_SEC_MAX = 8'h59;
  localparam logic [7:0] RTCR_HALF_MIN = 8'h30;
  localparam logic [7:0] RTCR_H24_MAX = 8'h23;
  localparam logic [7:0] RTCR_H12_TOP = 8'h12;
  localparam logic [7:0] RTCR_H12_PRE = 8'h11;
  localparam logic [7:0] RTCR_WDAY_MAX = 8'h06;
  localparam logic [7:0] RTCR_MON_MAX = 8'h12;
  localparam logic [7:0] RTCR_YEAR_MAX = 8'h99;
  localparam logic [1:0] RTCR_LEAP_NOW = 2'b00;
  // Timing: 125 MHz clock, 1/16 s sub-tick
  localparam int RTCR_CLK_PERIOD_NS = 8;
  localparam int RTCR_SUB_TICK_NS = 62_500_000;
  localparam int RTCR_SUB_TICK_CYCLES = RTCR_SUB_TICK_NS / RTCR_CLK_PERIOD_NS;
  localparam int RTCR_SUBS_PER_SEC = 16;
endpackage

// file: rtcr_regs.sv
// Paged real-time-clock register file with APB slave and time counting
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module rtcr_regs #(
  parameter int unsigned SUB_TICK_CYCLES = rtcr_pkg::RTCR_SUB_TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rtcr_pkg::RTCR_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic alarm_out,
  output logic pulse_1hz,
  output logic pulse_16hz
);
  import rtcr_pkg::*;

  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [2:0] wday;
    logic [5:0] day;
    logic [4:0] mon;
    logic [7:0] year;
    logic [6:0] al_min;
    logic [5:0] al_hour;
    logic [2:0] al_wday;
    logic [5:0] al_day;
    logic h24;
    logic [1:0] leap;
    logic irq_en;
    logic adj;
    logic clk_en;
    logic al_en;
    logic page;
    logic en_1hz;
    logic en_16hz;
    logic rdy;
    logic err;
    logic [7:0] rdata;
    logic alarm;
    logic p1;
    logic p16;
  } rtcr_state_t;

  rtcr_state_t st, next_st;
  logic tick_16hz;
  logic tick_1hz;
  logic div_clr;
  logic [13:0] idx;
  logic acc_req;
  logic acc_done;

  assign idx = paddr[15:2];
  assign acc_req = psel && penable && !st.rdy;
  assign acc_done = psel && penable && st.rdy;
  // Divider restart is immediate so the next second is a full one
  assign div_clr = acc_done && pwrite && idx == RTCR_IDX_RESET && pwdata[RTCR_RS_DIV];

  rtcr_div #(
    .SUB_TICK_CYCLES(SUB_TICK_CYCLES)
  ) u_div (
    .mclk(mclk),
    .rst(rst),
    .clr(div_clr),
    .tick_16hz(tick_16hz),
    .tick_1hz(tick_1hz)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] low);
    logic [8:0] r;
    r = '0;
    if (v == top) begin
      r = {1'b1, low};
    end else if (v[3:0] == 4'h9) begin
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {1'b0, v + 8'h01};
    end
    return r;
  endfunction

  function automatic logic [7:0] month_len(input logic [4:0] m, input logic leap_now);
    logic [7:0] r;
    r = 8'h31;
    case (m)
      5'h02: r = leap_now ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: r = 8'h30;
      default: r = 8'h31;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] read_mux(input rtcr_state_t s, input logic [13:0] i);
    logic [7:0] r;
    r = '0;
    case (i)
      RTCR_IDX_SECONDS: r = s.page ? 8'h00 : {1'b0, s.sec};
      RTCR_IDX_MINUTES: r = s.page ? {1'b0, s.al_min} : {1'b0, s.min};
      RTCR_IDX_HOURS: r = s.page ? {2'b0, s.al_hour} : {2'b0, s.hour};
      RTCR_IDX_WEEKDAY: r = s.page ? {5'b0, s.al_wday} : {5'b0, s.wday};
      RTCR_IDX_DAY: r = s.page ? {2'b0, s.al_day} : {2'b0, s.day};
      RTCR_IDX_MONTH: r = s.page ? {7'b0, s.h24} : {3'b0, s.mon};
      RTCR_IDX_YEAR: r = s.page ? {6'b0, s.leap} : s.year;
      RTCR_IDX_PAGE: r = {s.irq_en, 2'b0, s.adj, s.clk_en, s.al_en, 1'b0, s.page};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  function automatic logic hit(input logic [13:0] i);
    return i >= RTCR_IDX_SECONDS && i <= RTCR_IDX_RESET;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [8:0] s_inc, m_inc, h_inc, d_inc, mo_inc, y_inc, w_inc;
  logic [7:0] h12;
  logic roll_min, roll_hour, roll_day, roll_mon;

  always_comb begin
    next_st = st;
    s_inc = bcd_inc({1'b0, st.sec}, RTCR_SEC_MAX, 8'h00);
    m_inc = bcd_inc({1'b0, st.min}, RTCR_SEC_MAX, 8'h00);
    h_inc = bcd_inc({2'b0, st.hour}, RTCR_H24_MAX, 8'h00);
    h12 = {3'b0, st.hour[4:0]};
    w_inc = bcd_inc({5'b0, st.wday}, RTCR_WDAY_MAX, 8'h00);
    d_inc = bcd_inc({2'b0, st.day}, month_len(st.mon, st.leap == RTCR_LEAP_NOW), 8'h01);
    mo_inc = bcd_inc({3'b0, st.mon}, RTCR_MON_MAX, 8'h01);
    y_inc = bcd_inc(st.year, RTCR_YEAR_MAX, 8'h00);
    roll_min = 1'b0;
    roll_hour = 1'b0;
    roll_day = 1'b0;
    roll_mon = 1'b0;
    next_st.p1 = tick_1hz && st.en_1hz;
    next_st.p16 = tick_16hz && st.en_16hz;

    // Once-a-second counting; adjustment rounds to the nearest minute
    if (tick_1hz && st.clk_en) begin
      if (st.adj) begin
        next_st.sec = '0;
        next_st.adj = 1'b0;
        roll_min = ({1'b0, st.sec} >= RTCR_HALF_MIN);
      end else begin
        next_st.sec = s_inc[6:0];
        roll_min = s_inc[8];
      end
    end
    if (roll_min) begin
      next_st.min = m_inc[6:0];
      roll_hour = m_inc[8];
    end
    if (roll_hour) begin
      if (st.h24) begin
        next_st.hour = h_inc[5:0];
        roll_day = h_inc[8];
      end else if (h12 == RTCR_H12_TOP) begin
        next_st.hour = {st.hour[5], 5'h01};
      end else if (h12 == RTCR_H12_PRE) begin
        // Bit 5 is the PM flag in 12-hour mode
        next_st.hour = {!st.hour[5], 5'h12};
        roll_day = st.hour[5];
      end else begin
        next_st.hour = {st.hour[5], 5'(bcd_inc(h12, RTCR_H12_TOP, 8'h01))};
      end
    end
    if (roll_day) begin
      next_st.wday = w_inc[2:0];
      next_st.day = d_inc[5:0];
      roll_mon = d_inc[8];
    end
    if (roll_mon) begin
      next_st.mon = mo_inc[4:0];
      if (mo_inc[8]) begin
        next_st.year = y_inc[7:0];
        next_st.leap = st.leap + 2'b01;
      end
    end

    // Alarm holds until cleared; a match in the clearing cycle wins
    if (acc_done && pwrite && idx == RTCR_IDX_RESET && pwdata[RTCR_RS_ALARM]) begin
      next_st.alarm = 1'b0;
    end
    if (st.al_en && st.sec == 7'h00 && st.min == st.al_min && st.hour == st.al_hour
        && st.wday == st.al_wday && st.day == st.al_day) begin
      next_st.alarm = 1'b1;
    end

    // APB: one wait state, then the transfer completes
    next_st.rdy = 1'b0;
    next_st.err = 1'b0;
    if (acc_req) begin
      next_st.rdy = 1'b1;
      next_st.err = !hit(idx);
      next_st.rdata = pwrite ? 8'h00 : read_mux(st, idx);
    end
    // Software writes land after counting, so a write wins over a tick
    if (acc_done && pwrite && hit(idx)) begin
      case (idx)
        RTCR_IDX_SECONDS: begin
          if (!st.page) begin
            next_st.sec = pwdata[6:0];
          end
        end
        RTCR_IDX_MINUTES: begin
          if (st.page) next_st.al_min = pwdata[6:0];
          else next_st.min = pwdata[6:0];
        end
        RTCR_IDX_HOURS: begin
          if (st.page) next_st.al_hour = pwdata[5:0];
          else next_st.hour = pwdata[5:0];
        end
        RTCR_IDX_WEEKDAY: begin
          if (st.page) next_st.al_wday = pwdata[2:0];
          else next_st.wday = pwdata[2:0];
        end
        RTCR_IDX_DAY: begin
          if (st.page) next_st.al_day = pwdata[5:0];
          else next_st.day = pwdata[5:0];
        end
        RTCR_IDX_MONTH: begin
          if (st.page) next_st.h24 = pwdata[0];
          else next_st.mon = pwdata[4:0];
        end
        RTCR_IDX_YEAR: begin
          if (st.page) next_st.leap = pwdata[1:0];
          else next_st.year = pwdata[7:0];
        end
        RTCR_IDX_PAGE: begin
          next_st.page = pwdata[RTCR_PG_PAGE];
          next_st.al_en = pwdata[RTCR_PG_AL_EN];
          next_st.clk_en = pwdata[RTCR_PG_CLK_EN];
          next_st.irq_en = pwdata[RTCR_PG_IRQ_EN];
          // Write wins over the self-clear at a tick; writing 0 withdraws a request
          next_st.adj = pwdata[RTCR_PG_ADJ];
        end
        RTCR_IDX_RESET: begin
          next_st.en_1hz = pwdata[RTCR_RS_EN1];
          next_st.en_16hz = pwdata[RTCR_RS_EN16];
        end
        default: begin
          next_st.page = st.page;
        end
      endcase
    end
  end

  // Only bus handshake, alarm flag and output pulses reset; clock state survives reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      st.rdy <= 1'b0;
      st.err <= 1'b0;
      st.rdata <= 8'h00;
      st.alarm <= 1'b0;
      st.p1 <= 1'b0;
      st.p16 <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = {24'h00_0000, st.rdata};
  assign pready = st.rdy;
  assign pslverr = st.err;
  assign alarm_out = st.alarm;
  assign pulse_1hz = st.p1;
  assign pulse_16hz = st.p16;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_rd(logic [13:0] i);
    psel && penable && !pready && !pwrite && idx == i;
  endsequence

  sequence s_wr_done(logic [13:0] i);
    psel && penable && pready && pwrite && idx == i;
  endsequence

  // Counts are undefined until programmed, so only a known-low clk_en bit arms this
  a_hold_in_reset: assert property (disable iff (1'b0)
    rst && !st.clk_en
    |=> st.sec == $past(st.sec) && st.year == $past(st.year) && st.page == $past(st.page))
    else $error("Clock state changed during reset");

  a_live_seconds: assert property (s_rd(RTCR_IDX_SECONDS) ##0 !st.page
    |=> pready && prdata == {25'h0, $past(st.sec)})
    else $error("Page 0 seconds read not live");

  a_alarm_min_read: assert property (s_rd(RTCR_IDX_MINUTES) ##0 st.page
    |=> prdata[6:0] == $past(st.al_min) && prdata[31:7] == 25'h0)
    else $error("Page 1 minute read not alarm setting");

  a_sec_top_zero: assert property (s_rd(RTCR_IDX_SECONDS) |=> prdata[7] == 1'b0)
    else $error("Seconds bit 7 not zero");

  a_weekday_width: assert property (s_rd(RTCR_IDX_WEEKDAY)
    |=> prdata[7:3] == 5'h00)
    else $error("Weekday upper bits not zero");

  a_year_byte: assert property (s_rd(RTCR_IDX_YEAR) ##0 !st.page
    |=> prdata[7:0] == $past(st.year))
    else $error("Year read wrong");

  a_hours_map: assert property (s_rd(RTCR_IDX_HOURS) ##0 !st.page
    |=> prdata[7:0] == {2'b00, $past(st.hour)})
    else $error("Page 0 hours read wrong");

  a_mode_page1: assert property (s_wr_done(RTCR_IDX_MONTH) ##0 st.page
    |=> st.h24 == $past(pwdata[0]) ##1 st.h24 == $past(st.h24))
    else $error("Hour mode select not stored");

  a_page_select: assert property (s_wr_done(RTCR_IDX_PAGE)
    |=> st.page == $past(pwdata[0]) && st.clk_en == $past(pwdata[3]))
    else $error("Page and control write lost");

  a_reset_reg_read: assert property (s_rd(RTCR_IDX_RESET)
    |=> pready && prdata == 32'h0000_0000 && !pslverr)
    else $error("Reset register not write-only");

  a_alarm_clear: assert property (s_wr_done(RTCR_IDX_RESET) ##0 pwdata[4] && !st.al_en
    |=> !alarm_out)
    else $error("Alarm reset did not clear output");
endmodule
`default_nettype wire
